// file: adcc_top.sv
// Control, sequencing and result logic of a 10-bit successive-approximation
// converter. Assumes the analog comparator chain outside delivers a settled
// code on sar_result by the end of the conversion time, and that the CPU
// side drives the register port synchronously to clk.
`timescale 1ns/1ns

module adcc_top #(
  parameter int BASE_CYCLES = adcc_pkg::ADCC_BASE_CYCLES
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic low_power_entry,
  input wire logic [9:0] sar_result,
  output logic [7:0] analog_channel_enable,
  output logic conversion_active,
  output logic conversion_done_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  adcc_pkg::adcc_state_reg_t state_reg;
  adcc_pkg::adcc_state_reg_t state_next;
  adcc_pkg::adcc_bus_req_t req;

  assign req.addr = bus_addr;
  assign req.wdata = bus_wdata;
  assign req.wr = bus_wr;
  assign req.rd = bus_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion length for a time code

  // Reserved codes fall back to the longest time so a stray setting never
  // shortens sampling below what the analog side can settle in.
  function automatic logic [adcc_pkg::ADCC_CNT_W-1:0] conv_cycles(
    input logic [2:0] code
  );
    logic [2:0] eff;
    logic [adcc_pkg::ADCC_CNT_W-1:0] base;
    eff = (code > adcc_pkg::ADCC_TIME_LAST) ? adcc_pkg::ADCC_TIME_LAST : code;
    base = adcc_pkg::ADCC_CNT_W'(BASE_CYCLES);
    conv_cycles = base << eff;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel enable decode

  logic [7:0] chan_decode;

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_chan
      assign chan_decode[i] = state_next.analog_input_enable && (state_next.chan == 4'(i));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic is_ctl_one;
  logic is_ctl_two;
  logic is_res_low;
  logic is_res_high;
  logic mode_off_write;

  assign is_ctl_one = (req.addr == adcc_pkg::ADCC_OFF_CTL_ONE);
  assign is_ctl_two = (req.addr == adcc_pkg::ADCC_OFF_CTL_TWO);
  assign is_res_low = (req.addr == adcc_pkg::ADCC_OFF_RES_LOW);
  assign is_res_high = (req.addr == adcc_pkg::ADCC_OFF_RES_HIGH);
  assign mode_off_write = req.wr && is_ctl_one &&
    (req.wdata[adcc_pkg::ADCC_C1_MODE_HI:adcc_pkg::ADCC_C1_MODE_LO] ==
     adcc_pkg::ADCC_MODE_OFF);

  always_comb
  begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    state_next.rdata = adcc_pkg::ADCC_REG_RESET;

    // Register writes
    if (req.wr && is_ctl_one)
    begin
      state_next.start = req.wdata[adcc_pkg::ADCC_C1_START_BIT];
      state_next.mode =
        req.wdata[adcc_pkg::ADCC_C1_MODE_HI:adcc_pkg::ADCC_C1_MODE_LO];
      state_next.analog_input_enable = req.wdata[adcc_pkg::ADCC_C1_ANALOG_INPUT_ENABLE_BIT];
      state_next.chan = req.wdata[adcc_pkg::ADCC_C1_CHAN_HI:0];
    end
    if (req.wr && is_ctl_two)
    begin
      // Bits 3..7 are not stored; bit 3 is expected to be written as zero
      state_next.conv_time = req.wdata[adcc_pkg::ADCC_C2_TIME_HI:0];
    end

    // Register reads: data stand in the following cycle only
    if (req.rd)
    begin
      if (is_ctl_one)
      begin
        state_next.rdata = {state_reg.start, state_reg.mode, state_reg.analog_input_enable,
          state_reg.chan};
      end
      else if (is_ctl_two)
      begin
        state_next.rdata = {state_reg.eoc, state_reg.busy, 3'h0,
          state_reg.conv_time};
      end
      else if (is_res_low)
      begin
        state_next.rdata = state_reg.result[7:0];
        state_next.low_read = 1'b1;
      end
      else if (is_res_high)
      begin
        state_next.rdata = {6'h00, state_reg.result[9:8]};
        state_next.low_read = 1'b0;
        state_next.eoc = 1'b0;
      end
      else
      begin
        state_next.rdata = adcc_pkg::ADCC_REG_RESET;
      end
    end

    // Sequencer; its flag sets come after the read clears so a set wins
    case (state_reg.state)
      adcc_pkg::ADCC_IDLE:
      begin
        if (state_reg.start)
        begin
          state_next.start = 1'b0;
          if (state_reg.mode == adcc_pkg::ADCC_MODE_SINGLE ||
              state_reg.mode == adcc_pkg::ADCC_MODE_REPEAT)
          begin
            state_next.state = adcc_pkg::ADCC_CONVERT;
            state_next.cnt = conv_cycles(state_reg.conv_time) -
              adcc_pkg::ADCC_CNT_W'(1);
            state_next.busy = 1'b1;
            if (state_reg.mode == adcc_pkg::ADCC_MODE_SINGLE)
            begin
              state_next.eoc = 1'b0;
            end
          end
        end
      end
      adcc_pkg::ADCC_CONVERT:
      begin
        if (state_reg.cnt == '0)
        begin
          state_next.state = adcc_pkg::ADCC_STORE;
        end
        else
        begin
          state_next.cnt = state_reg.cnt - adcc_pkg::ADCC_CNT_W'(1);
        end
      end
      adcc_pkg::ADCC_STORE:
      begin
        // One cycle of store overhead keeps well inside the allowed latency
        if (state_reg.low_read)
        begin
          // Torn read in progress: keep the old pair, drop the new code
          state_next.low_read = state_next.low_read;
        end
        else
        begin
          state_next.result = sar_result;
          state_next.eoc = 1'b1;
          state_next.irq = 1'b1;
        end
        if (state_reg.mode == adcc_pkg::ADCC_MODE_REPEAT)
        begin
          state_next.state = adcc_pkg::ADCC_CONVERT;
          state_next.cnt = conv_cycles(state_reg.conv_time) -
            adcc_pkg::ADCC_CNT_W'(1);
        end
        else
        begin
          state_next.state = adcc_pkg::ADCC_IDLE;
          state_next.busy = 1'b0;
        end
      end
      default:
      begin
        state_next.state = adcc_pkg::ADCC_IDLE;
        state_next.busy = 1'b0;
      end
    endcase

    // Forced stop: nothing in flight survives, no result is stored
    if (mode_off_write)
    begin
      state_next.state = adcc_pkg::ADCC_IDLE;
      state_next.busy = 1'b0;
      state_next.eoc = 1'b0;
      state_next.irq = 1'b0;
      state_next.result = adcc_pkg::ADCC_RESULT_RESET;
      state_next.low_read = 1'b0;
      state_next.cnt = '0;
    end

    // Low-power entry wins over the sequencer and a control write this cycle, except the chan and conv_time fields
    if (low_power_entry)
    begin
      state_next.state = adcc_pkg::ADCC_IDLE;
      state_next.start = 1'b0;
      state_next.mode = adcc_pkg::ADCC_MODE_OFF;
      state_next.analog_input_enable = 1'b0;
      state_next.busy = 1'b0;
      state_next.eoc = 1'b0;
      state_next.irq = 1'b0;
      state_next.result = adcc_pkg::ADCC_RESULT_RESET;
      state_next.low_read = 1'b0;
      state_next.cnt = '0;
    end

    state_next.ain_en = chan_decode;
    state_next.active = (state_next.state != adcc_pkg::ADCC_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg.state <= adcc_pkg::ADCC_IDLE;
      state_reg.start <= 1'b0;
      state_reg.mode <= adcc_pkg::ADCC_MODE_OFF;
      state_reg.analog_input_enable <= 1'b0;
      state_reg.chan <= 4'h0;
      state_reg.conv_time <= 3'h0;
      state_reg.busy <= 1'b0;
      state_reg.eoc <= 1'b0;
      state_reg.result <= adcc_pkg::ADCC_RESULT_RESET;
      state_reg.low_read <= 1'b0;
      state_reg.cnt <= '0;
      state_reg.rdata <= adcc_pkg::ADCC_REG_RESET;
      state_reg.irq <= 1'b0;
      state_reg.ain_en <= 8'h00;
      state_reg.active <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign bus_rdata = state_reg.rdata;
  assign analog_channel_enable = state_reg.ain_en;
  assign conversion_active = state_reg.active;
  assign conversion_done_irq = state_reg.irq;

endmodule

// file: adcc_pkg.sv
// Shared constants and types for the converter control unit.
// Assumes an 8-bit register port and one synchronous clock domain.
package adcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [11:0] ADCC_OFF_CTL_ONE = 12'h0034;
  localparam logic [11:0] ADCC_OFF_CTL_TWO = 12'h0035;
  localparam logic [11:0] ADCC_OFF_RES_LOW = 12'h0036;
  localparam logic [11:0] ADCC_OFF_RES_HIGH = 12'h0037;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ADCC_C1_START_BIT = 7;
  localparam int ADCC_C1_MODE_HI = 6;
  localparam int ADCC_C1_MODE_LO = 5;
  localparam int ADCC_C1_ANALOG_INPUT_ENABLE_BIT = 4;
  localparam int ADCC_C1_CHAN_HI = 3;
  localparam int ADCC_C2_EOC_BIT = 7;
  localparam int ADCC_C2_BUSY_BIT = 6;
  localparam int ADCC_C2_TIME_HI = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings and reset values
  localparam logic [1:0] ADCC_MODE_OFF = 2'h0;
  localparam logic [1:0] ADCC_MODE_SINGLE = 2'h1;
  localparam logic [1:0] ADCC_MODE_REPEAT = 2'h3;
  localparam logic [2:0] ADCC_TIME_LAST = 3'h5;
  localparam logic [3:0] ADCC_CHAN_COUNT = 4'h8;
  localparam logic [7:0] ADCC_REG_RESET = 8'h00;
  localparam logic [9:0] ADCC_RESULT_RESET = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: shortest conversion in fast-clock cycles, doubled per time code
  localparam int ADCC_BASE_CYCLES = 39;
  localparam int ADCC_CNT_W = 11;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONVERT,
    ADCC_STORE
  } adcc_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_req_t;

  typedef struct packed {
    adcc_state_t state;
    logic start;
    logic [1:0] mode;
    logic analog_input_enable;
    logic [3:0] chan;
    logic [2:0] conv_time;
    logic busy;
    logic eoc;
    logic [9:0] result;
    logic low_read;
    logic [ADCC_CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] ain_en;
    logic active;
  } adcc_state_reg_t;

endpackage

// file: adcc_analog_model.sv
// Analog side model: a code per enabled channel.
// Assumes the design samples sar_result while conversion_active is high.
`timescale 1ns/1ns
module adcc_analog_model (
  input wire logic clk,
  input wire logic [7:0] analog_channel_enable,
  input wire logic conversion_active,
  input wire logic conversion_done_irq,
  output logic [9:0] sar_result
);
  logic [1:0] done_cnt = 2'h0;
  logic [9:0] junk = 10'h155;
  logic [2:0] ch;
  always_comb
  begin
    ch = 3'h0;
    for (int i = 0; i < 8; i++)
      if (analog_channel_enable[i])
        ch = 3'(i);
  end
  // Count stored results so a discarded code differs from the kept one
  always @(posedge clk)
  begin
    done_cnt <= done_cnt + {1'b0, conversion_done_irq};
    junk <= ~junk;
  end
  // Toggling junk while idle, so a sample taken at the wrong time shows
  assign sar_result = conversion_active ? {done_cnt, 5'h15, ch} : junk;
endmodule

// file: adcc_chk_sva.sv
// Port checks of the converter control unit.
// Bound into adcc_top; one clock domain.
`timescale 1ns/1ns
module adcc_chk #(
  parameter int BASE_CYCLES = 39
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic low_power_entry,
  input wire logic conversion_active,
  input wire logic conversion_done_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_arm;
    bus_wr && bus_addr == 12'h034 && bus_wdata[5] && !conversion_active && !low_power_entry;
  endsequence
  // Mode write, one idle cycle, then the start write with a running mode
  sequence s_go;
    s_arm ##2 (s_arm and bus_wdata[7]);
  endsequence
  AST_START_GO:
    assert property (s_go |-> ##2 conversion_active) else $error("start ignored");
  AST_STOP:
    assert property (bus_wr && bus_addr == 12'h034 && bus_wdata[6:5] == 2'h0
      |=> !conversion_active && !conversion_done_irq) else $error("stop late");
  AST_IRQ_ONE:
    assert property (conversion_done_irq |=> !conversion_done_irq) else $error("irq long");
  AST_IRQ_CAUSE:
    assert property (conversion_done_irq |-> $past(conversion_active, 2)
      && $past(conversion_active)) else $error("irq without conversion");
  AST_RDATA_QUIET:
    assert property (!$past(bus_rd) |-> bus_rdata == 8'h00) else $error("rdata stray");
  AST_LP_QUIET:
    assert property (low_power_entry |=> !conversion_active && !conversion_done_irq)
      else $error("low power ignored");
  AST_HIGH_ZERO:
    assert property (bus_rd && bus_addr == 12'h037 |=> bus_rdata[7:2] == 6'h00)
      else $error("high result bits");
  AST_CTL2_ZERO:
    assert property (bus_rd && bus_addr == 12'h035 |=> bus_rdata[5:3] == 3'h0)
      else $error("control two bits");
endmodule
bind adcc_top adcc_chk #(.BASE_CYCLES(BASE_CYCLES)) adcc_chk_inst (.clk(clk), .srst(srst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .low_power_entry(low_power_entry),
  .conversion_active(conversion_active), .conversion_done_irq(conversion_done_irq));

// file: sar_adc_control_unit_bench.sv
// Self-checking bench for adcc_top with the analog model.
// Short conversions: BASE_CYCLES lowered to 3.
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module sar_adc_control_unit_bench;
  localparam int BASE = 3;
  typedef struct packed {
    logic [11:0] wa;
    logic [7:0] wd;
    logic [11:0] ra;
    logic [7:0] rx;
    logic [7:0] ex;
  } adcc_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic low_power_entry = 1'b0;
  logic [7:0] bus_rdata, analog_channel_enable;
  logic conversion_active, conversion_done_irq;
  logic [9:0] sar_result;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int k;
  int nconv = 0;
  adcc_row_t rows [11] = '{
    '{12'h038, 8'h55, 12'h034, 8'h00, 8'h00}, '{12'h038, 8'h55, 12'h035, 8'h00, 8'h00},
    '{12'h038, 8'h55, 12'h036, 8'h00, 8'h00}, '{12'h038, 8'h55, 12'h037, 8'h00, 8'h00},
    '{12'h034, 8'h10, 12'h034, 8'h10, 8'h01}, '{12'h034, 8'h17, 12'h034, 8'h17, 8'h80},
    '{12'h034, 8'h18, 12'h034, 8'h18, 8'h00}, '{12'h034, 8'h07, 12'h034, 8'h07, 8'h00},
    '{12'h035, 8'hF7, 12'h035, 8'h07, 8'h00},
    '{12'h034, 8'hD2, 12'h038, 8'h00, 8'h04},
    '{12'h038, 8'h00, 12'h034, 8'h52, 8'h04}};
  adcc_top #(.BASE_CYCLES(BASE)) adcc_top_inst (.clk(clk), .srst(srst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .low_power_entry(low_power_entry), .sar_result(sar_result),
    .analog_channel_enable(analog_channel_enable), .conversion_active(conversion_active),
    .conversion_done_irq(conversion_done_irq));
  adcc_analog_model adcc_analog_model_inst (.clk(clk),
    .analog_channel_enable(analog_channel_enable), .conversion_active(conversion_active),
    .conversion_done_irq(conversion_done_irq), .sar_result(sar_result));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Two cycles per write, so the strobe never drops and rises in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
    @(posedge clk);
  endtask
  task automatic wait_irq(input int lim);
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (conversion_done_irq !== 1'b1 && k < lim);
    // Back on an edge so the next drive is a plain edge assignment
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      chk_rd(rows[i].ra, rows[i].rx);
      `CHK(analog_channel_enable, rows[i].ex)
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(12'h035, {5'h00, 3'(c)});
      wr(12'h034, {5'h06, 3'(c)});
      wr(12'h034, {5'h16, 3'(c)});
      @(posedge clk);
      chk_rd(12'h035, {5'h08, 3'(c)});
      wait_irq(200);
      `CHK(k + 4, (BASE << ((c > 5) ? 5 : c)) + 2)
      nconv++;
      chk_rd(12'h035, {5'h10, 3'(c)});
      chk_rd(12'h034, {5'h06, 3'(c)});
      `CHK(analog_channel_enable, 8'h01 << c)
    end
    chk_rd(12'h036, 8'hAF);
    chk_rd(12'h037, {6'h00, 2'(nconv - 1)});
    chk_rd(12'h035, 8'h07);
    wr(12'h034, 8'hB7);
    repeat (10) @(posedge clk);
    wr(12'h034, 8'h17);
    chk_rd(12'h035, 8'h07);
    chk_rd(12'h036, 8'h00);
    chk_rd(12'h037, 8'h00);
    wait_irq(150);
    `CHK(k, 150)
    wr(12'h035, 8'h00);
    wr(12'h034, 8'h72);
    wr(12'h034, 8'hF2);
    wait_irq(20);
    nconv++;
    wait_irq(20);
    `CHK(k + 1, BASE + 1)
    nconv++;
    chk_rd(12'h036, 8'hAA);
    wait_irq(12);
    `CHK(k, 12)
    chk_rd(12'h037, {6'h00, 2'(nconv - 1)});
    wait_irq(8);
    `CHK(k, 2)
    nconv++;
    wr(12'h034, 8'h15);
    wr(12'h034, 8'h35);
    wr(12'h034, 8'hB5);
    wait_irq(20);
    low_power_entry <= 1'b1;
    repeat (3) @(posedge clk);
    low_power_entry <= 1'b0;
    chk_rd(12'h034, 8'h05);
    chk_rd(12'h035, 8'h00);
    chk_rd(12'h036, 8'h00);
    `CHK(analog_channel_enable, 8'h00)
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk_rd(12'h034, 8'h00);
    complete_run();
  end
endmodule
